/* rtl/encoder_fault_pkg.sv */
// constants, register map and state type of the encoder fault monitor
package encoder_fault_pkg;

	// ==========================================================
	// register map (byte addresses)
	localparam int ADDR_W = 8;
	localparam logic [7:0] REG_CFG = 8'h00;
	localparam logic [7:0] REG_ROT_SPACING = 8'h04;
	localparam logic [7:0] REG_LIN_SPACING = 8'h08;
	localparam logic [7:0] REG_STATUS = 8'h0C;
	localparam logic [7:0] REG_IRQ_EN = 8'h10;
	localparam logic [7:0] REG_CLEAR = 8'h14;
	localparam logic [7:0] REG_VALUE0 = 8'h18;

	// ==========================================================
	// configuration fields
	localparam int CFG_LINEAR = 0;
	localparam int CFG_DIST_CODED = 1;
	localparam int CFG_DETAILED = 8;
	localparam int CFG_LEVEL_MON = 31;
	localparam int STATUS_PROPS = 8;
	localparam logic [31:0] CFG_RESET = 32'h0000_0000;
	localparam logic [31:0] SPACING_RESET = 32'h0000_0000;

	// ==========================================================
	// fault indices
	localparam int NUM_FAULTS = 5;
	localparam int F_SPACING = 0;
	localparam int F_MISSING = 1;
	localparam int F_LEVEL = 2;
	localparam int F_SERIAL = 3;
	localparam int F_INTERNAL = 4;

	// serial link error word bits produced here
	localparam int SER_NO_START = 2;
	localparam int SER_TOO_LONG = 8;

	// ==========================================================
	// timing and limits
	localparam int CLK_HZ = 40_000_000;
	localparam int START_TIMEOUT_MS = 50;
	localparam int START_TIMEOUT_CYC = START_TIMEOUT_MS * (CLK_HZ / 1000);
	localparam int MAX_FRAME_BITS = 64;
	localparam int INC_PER_PULSE = 4;
	localparam logic [15:0] LEVEL_500MV = 16'h5333;
	localparam logic [15:0] LEVEL_MAX = 16'h7FFF;
	localparam logic [15:0] LEVEL_MIN = 16'h8000;

	typedef struct packed {
		logic [31:0] cfg;
		logic [31:0] rot_spacing;
		logic [31:0] lin_spacing;
		logic [4:0] irq_en;
		logic [4:0] flags;
		logic [4:0][31:0] val;
		logic signed [31:0] pos_cnt;
		logic [31:0] travel;
		logic seen_mark;
		logic pair_open;
		logic [31:0] wd_cnt;
		logic [7:0] bit_cnt;
		logic [31:0] rdata;
	} state_t;

endpackage : encoder_fault_pkg

/* rtl/encoder_fault_monitor.sv */
// encoder fault monitor: zero mark, reference track, serial link and encoder error faults
//
// The implementer's own choices: the register offsets and strobed register access.
`timescale 1ns/1ps
`default_nettype none

module encoder_fault_monitor #(
	parameter int START_TIMEOUT = encoder_fault_pkg::START_TIMEOUT_CYC,
	parameter int FRAME_LIMIT = encoder_fault_pkg::MAX_FRAME_BITS,
	parameter int LEVEL_W = 18
) (
	// clock and reset
	input wire logic core_clk,
	input wire logic rst,
	// register port
	input wire logic [encoder_fault_pkg::ADDR_W-1:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata,
	// incremental position feedback
	input wire logic inc_step,
	input wire logic inc_dir,
	input wire logic zero_mark,
	// reference track supervision
	input wire logic module_props_available,
	input wire logic ref_line_pos_ok,
	input wire logic ref_line_neg_ok,
	input wire logic ref_diff_ok,
	input wire logic signed [LEVEL_W-1:0] ref_level,
	// serial link receiver
	input wire logic [15:0] serial_err_evt,
	input wire logic link_active,
	input wire logic link_start_bit,
	input wire logic link_data_bit,
	input wire logic link_frame_end,
	// encoder error word
	input wire logic enc_err_valid,
	input wire logic [31:0] enc_err_word,
	// fault outputs
	output logic mark_spacing_fault,
	output logic mark_missing_fault,
	output logic ref_track_level_fault,
	output logic serial_link_fault,
	output logic encoder_internal_fault,
	output logic irq
);

	// ==========================================================
	// helpers
	function automatic logic [31:0] mag(input logic signed [31:0] v);
		mag = v[31] ? 32'(-v) : 32'(v);
	endfunction : mag

	function automatic logic [15:0] sat16(input logic signed [LEVEL_W-1:0] v);
		if (v > LEVEL_W'(32767))
			sat16 = encoder_fault_pkg::LEVEL_MAX;
		else if (v < -LEVEL_W'(32768))
			sat16 = encoder_fault_pkg::LEVEL_MIN;
		else
			sat16 = v[15:0];
	endfunction : sat16

	encoder_fault_pkg::state_t st;
	encoder_fault_pkg::state_t next_st;

	logic [31:0] spacing;
	logic [32:0] miss_limit;
	logic evaluate;
	logic level_bad;
	logic [4:0] ev;
	logic [4:0] clr;
	logic [4:0][31:0] ev_val;
	logic [15:0] ser_word;

	// ==========================================================
	// shared decodes
	always_comb begin
		spacing = st.cfg[encoder_fault_pkg::CFG_LINEAR] ? st.lin_spacing
			: st.rot_spacing;
		miss_limit = {1'b0, spacing} + {2'b00, spacing[31:1]};
		evaluate = st.cfg[encoder_fault_pkg::CFG_DIST_CODED] ? st.pair_open
			: st.seen_mark;
		level_bad = st.cfg[encoder_fault_pkg::CFG_LEVEL_MON] && module_props_available
			&& (!ref_line_pos_ok || !ref_line_neg_ok || !ref_diff_ok);
		clr = (reg_wr && reg_addr == encoder_fault_pkg::REG_CLEAR) ? reg_wdata[4:0] : 5'h00;
	end

	// ==========================================================
	// next state
	always_comb begin
		logic signed [31:0] pos_n;
		logic [31:0] travel_n;
		logic [31:0] wd_n;
		logic [7:0] bits_n;
		pos_n = st.pos_cnt;
		travel_n = st.travel;
		wd_n = st.wd_cnt;
		bits_n = st.bit_cnt;
		next_st = st;
		ev = 5'h00;
		ev_val = '0;
		ser_word = serial_err_evt;
		ser_word[encoder_fault_pkg::SER_NO_START] = 1'b0;
		ser_word[encoder_fault_pkg::SER_TOO_LONG] = 1'b0;

		// increment tracking, one count per quadrature edge
		if (inc_step) begin
			pos_n = inc_dir ? st.pos_cnt + 32'sd1 : st.pos_cnt - 32'sd1;
			travel_n = st.travel + 32'd1;
		end

		// missing mark: fires once as travel crosses the limit
		if (inc_step && !zero_mark && {1'b0, travel_n} == miss_limit + 33'd1) begin
			ev[encoder_fault_pkg::F_MISSING] = 1'b1;
			ev_val[encoder_fault_pkg::F_MISSING] = pos_n;
		end

		// zero mark: compare measured distance, then restart the count
		if (zero_mark) begin
			if (evaluate && mag(pos_n) != spacing) begin
				ev[encoder_fault_pkg::F_SPACING] = 1'b1;
				ev_val[encoder_fault_pkg::F_SPACING] = pos_n;
			end
			next_st.seen_mark = 1'b1;
			next_st.pair_open = st.cfg[encoder_fault_pkg::CFG_DIST_CODED]
				? !st.pair_open : 1'b0;
			pos_n = 32'sd0;
			travel_n = 32'd0;
		end
		next_st.pos_cnt = pos_n;
		next_st.travel = travel_n;

		// reference track level
		if (level_bad) begin
			ev[encoder_fault_pkg::F_LEVEL] = 1'b1;
			ev_val[encoder_fault_pkg::F_LEVEL] = {16'h0000, sat16(ref_level)};
		end

		// start bit watchdog while cyclic reading is requested
		if (!link_active || link_start_bit)
			wd_n = 32'd0;
		else if (st.wd_cnt == 32'(START_TIMEOUT - 1)) begin
			ser_word[encoder_fault_pkg::SER_NO_START] = 1'b1;
			wd_n = 32'd0;
		end else
			wd_n = st.wd_cnt + 32'd1;
		next_st.wd_cnt = wd_n;

		// frame length counter
		if (link_frame_end || link_start_bit)
			bits_n = 8'd0;
		else if (link_data_bit) begin
			if (st.bit_cnt == 8'(FRAME_LIMIT))
				ser_word[encoder_fault_pkg::SER_TOO_LONG] = 1'b1;
			else
				bits_n = st.bit_cnt + 8'd1;
		end
		next_st.bit_cnt = bits_n;

		if (|ser_word) begin
			ev[encoder_fault_pkg::F_SERIAL] = 1'b1;
			ev_val[encoder_fault_pkg::F_SERIAL] = {16'h0000, ser_word};
		end

		// encoder error word; opaque in plain mode, split in detailed mode
		if (enc_err_valid && (enc_err_word[15:0] != 16'h0000
			|| !st.cfg[encoder_fault_pkg::CFG_DETAILED])) begin
			ev[encoder_fault_pkg::F_INTERNAL] = enc_err_word != 32'h0000_0000;
			ev_val[encoder_fault_pkg::F_INTERNAL] = enc_err_word;
		end

		// sticky flags: a new event wins over a clear, first cause kept
		for (int i = 0; i < encoder_fault_pkg::NUM_FAULTS; i++) begin
			if (ev[i] && (!st.flags[i] || clr[i]))
				next_st.val[i] = ev_val[i];
			next_st.flags[i] = (st.flags[i] && !clr[i]) || ev[i];
		end

		// register writes
		if (reg_wr) begin
			if (reg_addr == encoder_fault_pkg::REG_CFG)
				next_st.cfg = reg_wdata;
			else if (reg_addr == encoder_fault_pkg::REG_ROT_SPACING)
				next_st.rot_spacing = reg_wdata;
			else if (reg_addr == encoder_fault_pkg::REG_LIN_SPACING)
				next_st.lin_spacing = reg_wdata;
			else if (reg_addr == encoder_fault_pkg::REG_IRQ_EN)
				next_st.irq_en = reg_wdata[4:0];
		end

		// register reads, answered one cycle later
		next_st.rdata = 32'h0000_0000;
		if (reg_rd) begin
			if (reg_addr == encoder_fault_pkg::REG_CFG)
				next_st.rdata = st.cfg;
			else if (reg_addr == encoder_fault_pkg::REG_ROT_SPACING)
				next_st.rdata = st.rot_spacing;
			else if (reg_addr == encoder_fault_pkg::REG_LIN_SPACING)
				next_st.rdata = st.lin_spacing;
			else if (reg_addr == encoder_fault_pkg::REG_STATUS)
				next_st.rdata = {23'h0, module_props_available, 3'h0, st.flags};
			else if (reg_addr == encoder_fault_pkg::REG_IRQ_EN)
				next_st.rdata = {27'h0, st.irq_en};
			else if (reg_addr >= encoder_fault_pkg::REG_VALUE0
				&& reg_addr < encoder_fault_pkg::REG_VALUE0 + 8'd20
				&& reg_addr[1:0] == 2'b00)
				next_st.rdata = st.val[3'((reg_addr - encoder_fault_pkg::REG_VALUE0) >> 2)];
		end
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			st <= '0;
			st.cfg <= encoder_fault_pkg::CFG_RESET;
			st.rot_spacing <= encoder_fault_pkg::SPACING_RESET;
			st.lin_spacing <= encoder_fault_pkg::SPACING_RESET;
		end else
			st <= next_st;
	end

	// ==========================================================
	// outputs
	assign reg_rdata = st.rdata;
	assign mark_spacing_fault = st.flags[encoder_fault_pkg::F_SPACING];
	assign mark_missing_fault = st.flags[encoder_fault_pkg::F_MISSING];
	assign ref_track_level_fault = st.flags[encoder_fault_pkg::F_LEVEL];
	assign serial_link_fault = st.flags[encoder_fault_pkg::F_SERIAL];
	assign encoder_internal_fault = st.flags[encoder_fault_pkg::F_INTERNAL];
	assign irq = |(st.flags & st.irq_en);

	// ==========================================================
	// assertions
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (rst);

	// count as the design sees it in this cycle, step included
	logic signed [31:0] chk_pos;
	logic [15:0] made_here;
	always_comb begin
		chk_pos = st.pos_cnt;
		if (inc_step)
			chk_pos = inc_dir ? st.pos_cnt + 32'sd1 : st.pos_cnt - 32'sd1;
		made_here = 16'h0000;
		made_here[encoder_fault_pkg::SER_NO_START] = 1'b1;
		made_here[encoder_fault_pkg::SER_TOO_LONG] = 1'b1;
	end

	property p_spacing_flag;
		zero_mark && evaluate && mag(chk_pos) != spacing |=> mark_spacing_fault;
	endproperty
	a_spacing_flag: assert property (p_spacing_flag) else $error("spacing fault missed");

	property p_spacing_value;
		zero_mark && evaluate && !mark_spacing_fault
			&& mag(chk_pos) != spacing |=> st.val[0] == $past(chk_pos);
	endproperty
	a_spacing_value: assert property (p_spacing_value) else $error("spacing value wrong");

	property p_pair_open;
		zero_mark && st.cfg[1] && !st.pair_open && !mark_spacing_fault |=> !mark_spacing_fault;
	endproperty
	a_pair_open: assert property (p_pair_open) else $error("fault on unpaired mark");

	property p_missing;
		inc_step && !zero_mark && {1'b0, st.travel} == miss_limit |=> mark_missing_fault;
	endproperty
	a_missing: assert property (p_missing) else $error("missing mark not flagged");

	property p_level_gate;
		!(st.cfg[31] && module_props_available) && !ref_track_level_fault
			|=> !ref_track_level_fault;
	endproperty
	a_level_gate: assert property (p_level_gate) else $error("level fault while gated");

	property p_level_upper;
		ref_track_level_fault |-> st.val[2][31:16] == 16'h0000;
	endproperty
	a_level_upper: assert property (p_level_upper) else $error("level upper half set");

	property p_level_sat;
		level_bad && !ref_track_level_fault && ref_level > LEVEL_W'(32767)
			|=> st.val[2][15:0] == 16'h7FFF;
	endproperty
	a_level_sat: assert property (p_level_sat) else $error("level not saturated");

	property p_watchdog;
		link_active && !link_start_bit && st.wd_cnt == 32'(START_TIMEOUT - 1)
			&& !serial_link_fault |=> serial_link_fault && st.val[3][2];
	endproperty
	a_watchdog: assert property (p_watchdog) else $error("start timeout missed");

	property p_hold;
		serial_link_fault && clr[3] == 1'b0 |=> serial_link_fault ##0 $stable(st.val[3]);
	endproperty
	a_hold: assert property (p_hold) else $error("held fault changed");

	property p_linear;
		zero_mark && evaluate && st.cfg[encoder_fault_pkg::CFG_LINEAR]
			&& mag(chk_pos) != st.lin_spacing |=> mark_spacing_fault;
	endproperty
	a_linear: assert property (p_linear) else $error("linear spacing missed");

	property p_miss_value;
		inc_step && !zero_mark && {1'b0, st.travel} == miss_limit && !mark_missing_fault
			|=> st.val[1] == $past(chk_pos);
	endproperty
	a_miss_value: assert property (p_miss_value) else $error("missing value");

	property p_level_flag;
		st.cfg[encoder_fault_pkg::CFG_LEVEL_MON] && module_props_available
			&& !(ref_line_pos_ok && ref_line_neg_ok && ref_diff_ok)
			|=> ref_track_level_fault;
	endproperty
	a_level_flag: assert property (p_level_flag) else $error("level missed");

	property p_level_value;
		level_bad && !ref_track_level_fault && ref_level <= LEVEL_W'(32767)
			&& ref_level >= -LEVEL_W'(32768)
			|=> st.val[2][15:0] == $past(ref_level[15:0]);
	endproperty
	a_level_value: assert property (p_level_value) else $error("level value");

	property p_level_floor;
		level_bad && !ref_track_level_fault && ref_level < -LEVEL_W'(32768)
			|=> st.val[2][15:0] == 16'h8000;
	endproperty
	a_level_floor: assert property (p_level_floor) else $error("level floor");

	property p_ser_flag;
		|(serial_err_evt & ~made_here) |=> serial_link_fault;
	endproperty
	a_ser_flag: assert property (p_ser_flag) else $error("serial fault missed");

	property p_ser_value;
		|(serial_err_evt & ~made_here) && !serial_link_fault
			|=> (st.val[3][15:0] | made_here) == ($past(serial_err_evt) | made_here);
	endproperty
	a_ser_value: assert property (p_ser_value) else $error("serial value");

	property p_too_long;
		link_data_bit && !link_frame_end && !link_start_bit && !serial_link_fault
			&& st.bit_cnt == 8'(FRAME_LIMIT)
			|=> serial_link_fault && st.val[3][encoder_fault_pkg::SER_TOO_LONG];
	endproperty
	a_too_long: assert property (p_too_long) else $error("long frame missed");

	property p_internal;
		enc_err_valid && st.cfg[encoder_fault_pkg::CFG_DETAILED]
			&& enc_err_word[15:0] != 16'h0000 && !encoder_internal_fault
			|=> encoder_internal_fault && st.val[4] == $past(enc_err_word);
	endproperty
	a_internal: assert property (p_internal) else $error("cause missed");

	property p_no_cause;
		enc_err_valid && st.cfg[encoder_fault_pkg::CFG_DETAILED]
			&& enc_err_word[15:0] == 16'h0000 && !encoder_internal_fault
			|=> !encoder_internal_fault;
	endproperty
	a_no_cause: assert property (p_no_cause) else $error("fault without cause");

	property p_clear;
		reg_wr && reg_addr == encoder_fault_pkg::REG_CLEAR
			&& reg_wdata[encoder_fault_pkg::F_SPACING] && !zero_mark |=> !mark_spacing_fault;
	endproperty
	a_clear: assert property (p_clear) else $error("clear ignored");

	c_spacing: cover property (zero_mark ##1 mark_spacing_fault);
	c_missing: cover property ($rose(mark_missing_fault));
	c_ack: cover property (serial_link_fault ##1 !serial_link_fault);
	c_pair: cover property (zero_mark && evaluate && st.cfg[encoder_fault_pkg::CFG_DIST_CODED]);
	c_level: cover property ($rose(ref_track_level_fault));

endmodule : encoder_fault_monitor

`default_nettype wire

/* verification/encoder_model.sv */
// incremental encoder model: quadrature steps and zero marks
`timescale 1ns/1ps
`default_nettype none

module encoder_model (
	// clock
	input wire logic core_clk,
	// position feedback
	output logic inc_step,
	output logic inc_dir,
	output logic zero_mark
);
	initial begin
		inc_step = 1'b0;
		inc_dir = 1'b1;
		zero_mark = 1'b0;
	end

	// n steps on back-to-back cycles, zero mark beside the last one if asked
	task automatic move(input int n, input logic dir, input logic mark);
		for (int i = 0; i < n; i++) begin
			@(posedge core_clk);
			inc_step <= 1'b1;
			inc_dir <= dir;
			zero_mark <= mark && (i == n - 1);
		end
		@(posedge core_clk);
		inc_step <= 1'b0;
		zero_mark <= 1'b0;
		// direction carries no meaning between steps
		inc_dir <= ~dir;
	endtask : move
endmodule : encoder_model

`default_nettype wire

/* verification/encoder_fault_monitor_tb.sv */
// self-checking testbench of the encoder fault monitor
`timescale 1ns/1ps
`default_nettype none

module encoder_fault_monitor_tb;
	localparam int TMO = 20;
	localparam logic [7:0] RA [8] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h18, 8'h40};
	logic core_clk = 1'b0;
	logic rst = 1'b1;
	logic [7:0] reg_addr = 8'h00;
	logic [31:0] reg_wdata = 32'h0000_0000;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [31:0] reg_rdata;
	logic inc_step, inc_dir, zero_mark, irq, rd_d;
	logic props = 1'b0;
	logic [2:0] ok = 3'b111;
	logic signed [17:0] ref_level = 18'sh0_0000;
	logic signed [17:0] lvl;
	logic [15:0] ser_evt = 16'h0000;
	logic link_active = 1'b0;
	logic link_start = 1'b0;
	logic link_data = 1'b0;
	logic link_end = 1'b0;
	logic err_valid = 1'b0;
	logic [31:0] err_word = 32'h0000_0000;
	wire logic [4:0] faults;
	logic [15:0] rnd = 16'h458F;
	logic [31:0] exp_q [$];
	int error_cnt = 0;
	int checks = 0;

	always #12.5 core_clk = ~core_clk;

	encoder_model encoder_model_inst (.core_clk(core_clk), .inc_step(inc_step),
		.inc_dir(inc_dir), .zero_mark(zero_mark));

	encoder_fault_monitor #(.START_TIMEOUT(TMO)) encoder_fault_monitor_inst (
		.core_clk(core_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .inc_step(inc_step),
		.inc_dir(inc_dir), .zero_mark(zero_mark), .module_props_available(props),
		.ref_line_pos_ok(ok[0]), .ref_line_neg_ok(ok[1]), .ref_diff_ok(ok[2]),
		.ref_level(ref_level), .serial_err_evt(ser_evt), .link_active(link_active),
		.link_start_bit(link_start), .link_data_bit(link_data), .link_frame_end(link_end),
		.enc_err_valid(err_valid), .enc_err_word(err_word),
		.mark_spacing_fault(faults[0]), .mark_missing_fault(faults[1]),
		.ref_track_level_fault(faults[2]), .serial_link_fault(faults[3]),
		.encoder_internal_fault(faults[4]), .irq(irq));

	function automatic logic [15:0] lfsr(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction : lfsr

	function automatic logic [15:0] sat(input logic signed [17:0] v);
		if (v > 18'sh0_7FFF) return 16'h7FFF;
		if (v < 18'sh3_8000) return 16'h8000;
		return v[15:0];
	endfunction : sat

	task automatic cmp(input string what, input logic [31:0] e, input logic [31:0] got);
		checks++;
		if (got !== e) begin
			error_cnt++;
			$display("[ERR] %s expected %h seen %h", what, e, got);
		end
	endtask : cmp

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge core_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge core_clk);
		reg_wr <= 1'b0;
	endtask : wr

	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		exp_q.push_back(e);
		@(posedge core_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge core_clk);
		reg_rd <= 1'b0;
	endtask : rd

	task automatic st(input logic [31:0] e);
		rd(encoder_fault_pkg::REG_STATUS, e);
	endtask : st

	task automatic val(input int i, input logic [31:0] e);
		rd(encoder_fault_pkg::REG_VALUE0 + 8'(4 * i), e);
	endtask : val

	task automatic clr(input logic [4:0] m);
		wr(encoder_fault_pkg::REG_CLEAR, {27'h000_0000, m});
	endtask : clr

	task automatic ci(input logic e, input logic [4:0] f);
		@(negedge core_clk);
		cmp("irq", {31'h0000_0000, e}, {31'h0000_0000, irq});
		cmp("fault outputs", {27'h000_0000, f}, {27'h000_0000, faults});
	endtask : ci

	task automatic ierr(input logic [31:0] w, input logic f);
		@(posedge core_clk);
		err_word <= w;
		err_valid <= 1'b1;
		@(posedge core_clk);
		err_valid <= 1'b0;
		err_word <= ~w;
		st({27'h000_0000, f, 4'h0});
		if (f) val(4, w);
		clr(5'h10);
	endtask : ierr

	task automatic report_and_stop;
		if (error_cnt == 0 && checks > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : report_and_stop

	// read data stand only in the cycle after the strobe
	always @(posedge core_clk) begin
		if (rd_d) cmp("reg_rdata", exp_q.pop_front(), reg_rdata);
		rd_d <= reg_rd;
	end

	initial begin
		repeat (30000) @(posedge core_clk);
		error_cnt++;
		report_and_stop();
	end

	initial begin
		rd_d = 1'b0;
		repeat (3) @(posedge core_clk);
		rst <= 1'b0;
		foreach (RA[i]) rd(RA[i], 32'h0000_0000);
		wr(encoder_fault_pkg::REG_IRQ_EN, 32'hFFFF_FFFF);
		rd(encoder_fault_pkg::REG_IRQ_EN, 32'h0000_001F);
		wr(encoder_fault_pkg::REG_STATUS, 32'hFFFF_FFFF);
		st(32'h0000_0000);
		// ==========================================================
		// zero mark spacing and missing mark
		wr(encoder_fault_pkg::REG_ROT_SPACING, 32'h0000_0028);
		encoder_model_inst.move(1, 1'b1, 1'b1);
		encoder_model_inst.move(40, 1'b1, 1'b1);
		st(32'h0000_0000);
		encoder_model_inst.move(36, 1'b1, 1'b1);
		st(32'h0000_0001);
		val(0, 32'h0000_0024);
		ci(1'b1, 5'h01);
		encoder_model_inst.move(30, 1'b1, 1'b1);
		val(0, 32'h0000_0024);
		wr(encoder_fault_pkg::REG_IRQ_EN, 32'h0000_001E);
		ci(1'b0, 5'h01);
		clr(5'h01);
		encoder_model_inst.move(36, 1'b0, 1'b1);
		val(0, 32'hFFFF_FFDC);
		clr(5'h01);
		encoder_model_inst.move(60, 1'b1, 1'b0);
		st(32'h0000_0000);
		encoder_model_inst.move(1, 1'b1, 1'b0);
		st(32'h0000_0002);
		val(1, 32'h0000_003D);
		ci(1'b1, 5'h02);
		clr(5'h02);
		ci(1'b0, 5'h00);
		wr(encoder_fault_pkg::REG_CFG, 32'h0000_0001);
		wr(encoder_fault_pkg::REG_LIN_SPACING, 32'h0000_0014);
		encoder_model_inst.move(1, 1'b1, 1'b1);
		clr(5'h1F);
		encoder_model_inst.move(20, 1'b1, 1'b1);
		st(32'h0000_0000);
		encoder_model_inst.move(40, 1'b1, 1'b1);
		val(0, 32'h0000_0028);
		clr(5'h1F);
		// distance-coded: only the second mark of each pair compares
		wr(encoder_fault_pkg::REG_CFG, 32'h0000_0002);
		encoder_model_inst.move(36, 1'b1, 1'b1);
		encoder_model_inst.move(40, 1'b1, 1'b1);
		encoder_model_inst.move(36, 1'b1, 1'b1);
		st(32'h0000_0000);
		encoder_model_inst.move(36, 1'b1, 1'b1);
		val(0, 32'h0000_0024);
		clr(5'h01);
		// ==========================================================
		// serial link error word
		wr(encoder_fault_pkg::REG_CFG, 32'h0000_0000);
		for (int i = 0; i < 16; i++) begin
			if (i == 2 || i == 8) continue;
			@(posedge core_clk);
			ser_evt <= 16'(1 << i);
			@(posedge core_clk);
			ser_evt <= 16'h0000;
			val(3, 32'(1 << i));
			clr(5'h08);
		end
		link_start <= 1'b1;
		@(posedge core_clk);
		link_start <= 1'b0;
		link_data <= 1'b1;
		repeat (64) @(posedge core_clk);
		link_data <= 1'b0;
		st(32'h0000_0000);
		link_data <= 1'b1;
		@(posedge core_clk);
		link_data <= 1'b0;
		link_end <= 1'b1;
		@(posedge core_clk);
		link_end <= 1'b0;
		val(3, 32'h0000_0100);
		clr(5'h08);
		link_active <= 1'b1;
		repeat (TMO + 5) @(posedge core_clk);
		link_active <= 1'b0;
		val(3, 32'h0000_0004);
		clr(5'h08);
		// ==========================================================
		// encoder error word
		wr(encoder_fault_pkg::REG_CFG, 32'h0000_0100);
		for (int i = 0; i < 8; i++) begin
			rnd = lfsr(rnd);
			ierr(i < 7 ? 32'(1 << i) : {rnd, rnd | 16'h0001}, 1'b1);
		end
		ierr(32'h0001_0000, 1'b0);
		wr(encoder_fault_pkg::REG_CFG, 32'h0000_0000);
		ierr(32'h0001_0000, 1'b1);
		// ==========================================================
		// reference track level
		wr(encoder_fault_pkg::REG_CFG, 32'h8000_0000);
		ok <= 3'b110;
		st(32'h0000_0000);
		ok <= 3'b111;
		props <= 1'b1;
		for (int k = 0; k < 3; k++) begin
			rnd = lfsr(rnd);
			// the first two levels lie outside the 16-bit range on either side
			lvl = {k == 0 ? 2'b01 : (k == 1 ? 2'b10 : rnd[1:0]), rnd};
			ref_level <= lvl;
			ok <= ~(3'b001 << k);
			st(32'h0000_0104);
			val(2, {16'h0000, sat(lvl)});
			ok <= 3'b111;
			clr(5'h04);
		end
		st(32'h0000_0100);
		wr(encoder_fault_pkg::REG_CFG, 32'h0000_0000);
		ok <= 3'b110;
		st(32'h0000_0100);
		ok <= 3'b111;
		repeat (2) @(posedge core_clk);
		report_and_stop();
	end
endmodule : encoder_fault_monitor_tb

`default_nettype wire
